/* File: rtl/pmc_ctrl.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Five modes active, idle, standby, shutdown, held; software picks one.
// - Active runs processor and all enabled peripherals on any clock.
// - Idle stops core and memory clocks; any interrupt returns active.
// - Retention full in active/idle/standby, none shutdown/held.
// - Standby keeps only always-on domain; pin, timer or sensor wakes.
// - Standby wake keeps peripheral setup and resumes processor in place.
// - All general-purpose pins stay latched throughout standby.
// - Shutdown powers all off and latches pins at prior values.
// - Level change on enabled wake pin leaves shutdown as a reset.
// - Reset cause is readable: shutdown wake, reset pin or power-on.
// - Only latched pins and nonvolatile memory survive shutdown.
// - Reset pin wakes the device from every mode.
// - Fast clock from RC or crystal; radio only with crystal.
// - Medium clock always from its RC oscillator, feeds power logic.
// - Slow clock from RC, watch crystal or external pin clock.
// - Slow clock resyncs radio timer entering and leaving standby.
// - Slow clock may be driven out unless it comes from a pin.
module pmc_ctrl #(
   parameter int N_WAKE = 8,
   parameter int N_IO   = 8
) (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [pmc_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   input  wire logic                       wvalid,
   output logic                            wready,
   output logic [1:0]                      bresp,
   output logic                            bvalid,
   input  wire logic                       bready,
   input  wire logic [pmc_pkg::ADDR_W-1:0] araddr,
   input  wire logic                       arvalid,
   output logic                            arready,
   output logic [31:0]                     rdata,
   output logic [1:0]                      rresp,
   output logic                            rvalid,
   input  wire logic                       rready,
   input  wire logic                       irq_any,
   input  wire logic [N_WAKE-1:0]          wake_pins,
   input  wire logic                       rtc_evt,
   input  wire logic                       sensor_evt,
   input  wire logic                       reset_pin_n,
   input  wire logic [N_IO-1:0]            gpio_drive,
   output logic      [N_IO-1:0]            gpio_pad,
   output pmc_pkg::pmc_gate_t              gates,
   output pmc_pkg::pmc_clk_t               clk_cfg,
   output logic                            lf_resync,
   output logic                            sys_reset
);
   localparam int SW = N_WAKE + 3;

   pmc_pkg::pmc_mode_t  mode_r;
   pmc_pkg::pmc_mode_t  mode_nxt;
   pmc_pkg::pmc_mode_t  req_mode;
   pmc_pkg::pmc_gate_t  gate_nxt;
   pmc_pkg::pmc_cause_t cause_r;
   logic [SW-1:0]       in_s;
   logic [SW-1:0]       in_prev_r;
   logic [N_WAKE-1:0]   wake_en_r;
   logic [N_WAKE-1:0]   wake_chg;
   logic                fast_xtal_r;
   logic [1:0]          slow_src_r;
   logic                slow_out_r;
   logic                io_latch_r;
   logic                pin_rst;
   logic                sd_wake;
   logic                stby_wake;
   logic                soft_rst;
   logic                wr_go;
   logic                rd_go;
   logic                wr_ctrl;
   logic                wr_wake;
   logic                wr_stat;
   logic                req_ok;
   logic [31:0]         ctrl_new;
   logic [31:0]         wake_new;
   logic [31:0]         rd_data;
   logic                rd_err;

   function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return m;
   endfunction

   function automatic logic legal_req(input pmc_pkg::pmc_mode_t m);
      return m == pmc_pkg::PMC_IDLE || m == pmc_pkg::PMC_STANDBY ||
             m == pmc_pkg::PMC_SHUTDOWN || m == pmc_pkg::PMC_HELD;
   endfunction

   function automatic pmc_pkg::pmc_gate_t gate_of(
         input pmc_pkg::pmc_mode_t m);
      pmc_pkg::pmc_gate_t g;
      logic run;
      logic stby;
      g = '0;
      run  = m == pmc_pkg::PMC_ACTIVE || m == pmc_pkg::PMC_IDLE;
      stby = m == pmc_pkg::PMC_STANDBY;
      g.cpu_clk     = m == pmc_pkg::PMC_ACTIVE;
      g.mem_clk     = m == pmc_pkg::PMC_ACTIVE;
      g.flash_on    = run;
      g.sram_on     = run;
      g.sram_retain = run || stby;
      g.reg_retain  = run || stby;
      g.periph_clk  = run;
      g.periph_pwr  = run;
      g.fast_clk    = run;
      g.medium_clk  = run || stby;
      g.slow_clk    = run || stby;
      g.aon_pwr     = run || stby;
      g.sensor_pwr  = run || stby;
      g.por_on      = run || stby;
      g.bod_on      = run;
      g.bod_duty    = stby;
      g.wdt_run     = run;
      g.wdt_on      = run || stby;
      return g;
   endfunction

   // Pins and always-on events arrive from other clock domains.
   pmc_sync #(
      .W    (SW),
      .INIT ({1'b1, {(SW - 1){1'b0}}})
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({reset_pin_n, sensor_evt, rtc_evt, wake_pins}),
      .q       (in_s)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_prev_r <= {1'b1, {(SW - 1){1'b0}}};
      end else begin
         in_prev_r <= in_s;
      end
   end

   assign pin_rst   = in_prev_r[SW-1] & ~in_s[SW-1];
   assign wake_chg  = (in_s[N_WAKE-1:0] ^ in_prev_r[N_WAKE-1:0]) & wake_en_r;
   assign sd_wake   = (mode_r == pmc_pkg::PMC_SHUTDOWN) && (|wake_chg);
   assign stby_wake = (|wake_chg) ||
                      (in_s[N_WAKE] && !in_prev_r[N_WAKE]) ||
                      (in_s[N_WAKE+1] && !in_prev_r[N_WAKE+1]);
   assign soft_rst  = pin_rst || sd_wake;
   assign gate_nxt  = gate_of(mode_nxt);

   // Writes take address and data in the same cycle.
   assign wr_go    = awvalid && wvalid && !bvalid;
   assign awready  = wr_go;
   assign wready   = wr_go;
   assign rd_go    = arvalid && !rvalid;
   assign arready  = !rvalid;
   assign wr_ctrl  = wr_go && awaddr == pmc_pkg::CTRL_OFS;
   assign wr_stat  = wr_go && awaddr == pmc_pkg::STAT_OFS;
   assign wr_wake  = wr_go && awaddr == pmc_pkg::WAKE_OFS;
   assign ctrl_new = wmerge({24'h0, 1'b0, slow_out_r, slow_src_r,
                             fast_xtal_r, 3'h0}, wdata, wstrb);
   assign wake_new = wmerge(32'(wake_en_r), wdata, wstrb);
   assign req_mode = pmc_pkg::pmc_mode_t'(wdata[pmc_pkg::CTRL_MODE_LSB +: 3]);
   assign req_ok   = wr_ctrl && wstrb[0] && legal_req(req_mode) &&
                     mode_r == pmc_pkg::PMC_ACTIVE;

   always_comb begin
      mode_nxt = mode_r;
      if (pin_rst) begin
         mode_nxt = pmc_pkg::PMC_ACTIVE;
      end else begin
         case (mode_r)
            pmc_pkg::PMC_ACTIVE: begin
               if (req_ok) begin
                  mode_nxt = req_mode;
               end
            end
            pmc_pkg::PMC_IDLE: begin
               if (irq_any) begin
                  mode_nxt = pmc_pkg::PMC_ACTIVE;
               end
            end
            pmc_pkg::PMC_STANDBY: begin
               if (stby_wake) begin
                  mode_nxt = pmc_pkg::PMC_ACTIVE;
               end
            end
            pmc_pkg::PMC_SHUTDOWN: begin
               if (sd_wake) begin
                  mode_nxt = pmc_pkg::PMC_ACTIVE;
               end
            end
            pmc_pkg::PMC_HELD: begin
               mode_nxt = pmc_pkg::PMC_HELD;
            end
            default: begin
               mode_nxt = pmc_pkg::PMC_ACTIVE;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r    <= pmc_pkg::PMC_ACTIVE;
         gates     <= gate_of(pmc_pkg::PMC_ACTIVE);
         lf_resync <= 1'b0;
      end else begin
         mode_r    <= mode_nxt;
         gates     <= gate_of(mode_nxt);
         gates.io_latch <= io_latch_r;
         lf_resync <= (mode_r != mode_nxt) &&
                      (mode_r == pmc_pkg::PMC_STANDBY ||
                       mode_nxt == pmc_pkg::PMC_STANDBY);
      end
   end

   // Clock selection; lost on any reset trigger since nothing keeps it.
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
         fast_xtal_r <= pmc_pkg::FAST_XTAL_RST;
         slow_src_r  <= pmc_pkg::SLOW_SRC_RST;
         slow_out_r  <= pmc_pkg::SLOW_OUT_RST;
      end else if (wr_ctrl) begin
         fast_xtal_r <= ctrl_new[pmc_pkg::CTRL_FAST_XTAL];
         slow_src_r  <= ctrl_new[pmc_pkg::CTRL_SLOW_LSB +: 2];
         slow_out_r  <= ctrl_new[pmc_pkg::CTRL_SLOW_OUT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
         wake_en_r <= '0;
      end else if (wr_wake) begin
         wake_en_r <= wake_new[N_WAKE-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_cfg <= '0;
      end else begin
         clk_cfg.fast_xtal <= fast_xtal_r;
         clk_cfg.slow_src  <= slow_src_r;
         clk_cfg.slow_out  <= slow_out_r &&
                              slow_src_r != pmc_pkg::SLOW_SRC_EXT &&
                              gate_nxt.slow_clk;
         clk_cfg.radio_ok  <= fast_xtal_r && gate_nxt.fast_clk;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cause_r   <= pmc_pkg::PMC_CAUSE_POR;
         sys_reset <= 1'b0;
      end else begin
         sys_reset <= soft_rst;
         if (pin_rst) begin
            cause_r <= pmc_pkg::PMC_CAUSE_PIN;
         end else if (sd_wake) begin
            cause_r <= pmc_pkg::PMC_CAUSE_WAKE;
         end
      end
   end

   // The latch outlives a shutdown wake so pins do not glitch while
   // software restores their setup; it drops on an explicit release.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         io_latch_r <= 1'b0;
      end else if (mode_r != pmc_pkg::PMC_STANDBY &&
                   (mode_nxt == pmc_pkg::PMC_STANDBY ||
                    mode_nxt == pmc_pkg::PMC_SHUTDOWN)) begin
         io_latch_r <= 1'b1;
      end else if (mode_r == pmc_pkg::PMC_STANDBY &&
                   mode_nxt != pmc_pkg::PMC_STANDBY) begin
         io_latch_r <= 1'b0;
      end else if (wr_ctrl && wstrb[0] && wdata[pmc_pkg::CTRL_UNLATCH] &&
                   mode_r == pmc_pkg::PMC_ACTIVE) begin
         io_latch_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gpio_pad <= '0;
      end else if (!io_latch_r) begin
         gpio_pad <= gpio_drive;
      end
   end

   always_comb begin
      rd_data = 32'h0;
      rd_err  = 1'b0;
      case (araddr)
         pmc_pkg::CTRL_OFS: begin
            rd_data[pmc_pkg::CTRL_MODE_LSB +: 3] = mode_r;
            rd_data[pmc_pkg::CTRL_FAST_XTAL]     = fast_xtal_r;
            rd_data[pmc_pkg::CTRL_SLOW_LSB +: 2] = slow_src_r;
            rd_data[pmc_pkg::CTRL_SLOW_OUT]      = slow_out_r;
         end
         pmc_pkg::STAT_OFS: begin
            rd_data[pmc_pkg::STAT_MODE_LSB +: 3]  = mode_r;
            rd_data[pmc_pkg::STAT_CAUSE_LSB +: 2] = cause_r;
            rd_data[pmc_pkg::STAT_RADIO]          = clk_cfg.radio_ok;
            rd_data[pmc_pkg::STAT_LATCH]          = io_latch_r;
         end
         pmc_pkg::WAKE_OFS: begin
            rd_data[N_WAKE-1:0] = wake_en_r;
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= pmc_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp  <= (wr_ctrl || wr_stat || wr_wake) ?
                   pmc_pkg::RESP_OKAY : pmc_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0;
         rresp  <= pmc_pkg::RESP_OKAY;
      end else if (rd_go) begin
         rvalid <= 1'b1;
         rdata  <= rd_data;
         rresp  <= rd_err ? pmc_pkg::RESP_SLVERR : pmc_pkg::RESP_OKAY;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   req_mode_a: assert property (req_ok && !pin_rst |=>
      mode_r == $past(req_mode)) else $error("mode request not taken");
   active_run_a: assert property (mode_r == pmc_pkg::PMC_ACTIVE |->
      gates.cpu_clk && gates.periph_clk) else $error("active not running");
   idle_exit_a: assert property (mode_r == pmc_pkg::PMC_IDLE && irq_any
      |=> mode_r == pmc_pkg::PMC_ACTIVE && gates.cpu_clk)
      else $error("idle did not wake");
   idle_gate_a: assert property (mode_r == pmc_pkg::PMC_IDLE |->
      !gates.cpu_clk && !gates.mem_clk && gates.periph_clk)
      else $error("idle gating wrong");
   retain_a: assert property (mode_r == pmc_pkg::PMC_STANDBY |->
      gates.sram_retain && gates.reg_retain && !gates.periph_pwr)
      else $error("standby retention wrong");
   stby_hold_a: assert property (mode_r == pmc_pkg::PMC_STANDBY &&
      !stby_wake && !pin_rst |=> mode_r == pmc_pkg::PMC_STANDBY)
      else $error("standby left without wake");
   stby_setup_a: assert property (mode_r == pmc_pkg::PMC_STANDBY
      |=> $stable(fast_xtal_r) || mode_r == pmc_pkg::PMC_ACTIVE)
      else $error("setup lost in standby");
   pad_hold_a: assert property (io_latch_r |=> $stable(gpio_pad))
      else $error("latched pad moved");
   sd_enter_a: assert property (mode_r != pmc_pkg::PMC_SHUTDOWN ##1
      mode_r == pmc_pkg::PMC_SHUTDOWN |-> io_latch_r &&
      !gates.aon_pwr && !gates.sensor_pwr)
      else $error("shutdown entry wrong");
   sd_wake_a: assert property (sd_wake && !pin_rst |=>
      sys_reset && cause_r == pmc_pkg::PMC_CAUSE_WAKE &&
      mode_r == pmc_pkg::PMC_ACTIVE) else $error("shutdown wake lost");
   sd_lost_a: assert property (sd_wake |=> wake_en_r == '0 &&
      !fast_xtal_r && io_latch_r) else $error("shutdown kept state");
   pin_wake_a: assert property (pin_rst |=> sys_reset &&
      cause_r == pmc_pkg::PMC_CAUSE_PIN ##0 mode_r == pmc_pkg::PMC_ACTIVE)
      else $error("reset pin ignored");
   radio_xtal_a: assert property (clk_cfg.radio_ok |->
      clk_cfg.fast_xtal && gates.fast_clk) else $error("radio on RC");
   resync_a: assert property ($changed(mode_r) &&
      (mode_r == pmc_pkg::PMC_STANDBY ||
       $past(mode_r) == pmc_pkg::PMC_STANDBY) |-> lf_resync)
      else $error("no radio timer resync");
   slow_out_a: assert property (clk_cfg.slow_out |->
      clk_cfg.slow_src != pmc_pkg::SLOW_SRC_EXT && gates.slow_clk)
      else $error("slow clock driven out wrongly");
   clk_off_a: assert property (mode_r == pmc_pkg::PMC_SHUTDOWN ||
      mode_r == pmc_pkg::PMC_HELD |-> !gates.fast_clk &&
      !gates.medium_clk && !gates.slow_clk) else $error("clock left on");
   wdt_stby_a: assert property (mode_r == pmc_pkg::PMC_STANDBY |->
      gates.bod_duty && !gates.wdt_run && gates.wdt_on &&
      gates.medium_clk) else $error("standby supervision wrong");

   idle_cycle_c: cover property (mode_r == pmc_pkg::PMC_IDLE ##1
      mode_r == pmc_pkg::PMC_ACTIVE);
   stby_cycle_c: cover property (mode_r == pmc_pkg::PMC_STANDBY ##1
      mode_r == pmc_pkg::PMC_ACTIVE);
   sd_wake_c: cover property (sd_wake);
   held_pin_c: cover property (mode_r == pmc_pkg::PMC_HELD && pin_rst);
endmodule // pmc_ctrl

/* File: rtl/pmc_pkg.sv */
package pmc_pkg;
   typedef enum logic [2:0] {
      PMC_ACTIVE   = 3'h0,
      PMC_IDLE     = 3'h1,
      PMC_STANDBY  = 3'h3,
      PMC_SHUTDOWN = 3'h2,
      PMC_HELD     = 3'h6
   } pmc_mode_t;

   typedef enum logic [1:0] {
      PMC_CAUSE_POR  = 2'h0,
      PMC_CAUSE_PIN  = 2'h1,
      PMC_CAUSE_WAKE = 2'h2
   } pmc_cause_t;

   // Nominal clock rates, for reference by clock generators.
   localparam int FAST_CLK_HZ   = 48_000_000;
   localparam int MEDIUM_CLK_HZ = 2_000_000;
   localparam int SLOW_CLK_HZ   = 32_768;

   localparam logic [1:0] SLOW_SRC_RC   = 2'h0;
   localparam logic [1:0] SLOW_SRC_XTAL = 2'h1;
   localparam logic [1:0] SLOW_SRC_EXT  = 2'h2;

   localparam int         ADDR_W   = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] WAKE_OFS = 8'h08;

   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_FAST_XTAL = 3;
   localparam int CTRL_SLOW_LSB  = 4;
   localparam int CTRL_SLOW_OUT  = 6;
   localparam int CTRL_UNLATCH   = 7;
   localparam int STAT_MODE_LSB  = 0;
   localparam int STAT_CAUSE_LSB = 3;
   localparam int STAT_RADIO     = 5;
   localparam int STAT_LATCH     = 6;

   localparam logic       FAST_XTAL_RST = 1'b0;
   localparam logic [1:0] SLOW_SRC_RST  = SLOW_SRC_RC;
   localparam logic       SLOW_OUT_RST  = 1'b0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic cpu_clk;
      logic mem_clk;
      logic flash_on;
      logic sram_on;
      logic sram_retain;
      logic reg_retain;
      logic periph_clk;
      logic periph_pwr;
      logic fast_clk;
      logic medium_clk;
      logic slow_clk;
      logic aon_pwr;
      logic sensor_pwr;
      logic por_on;
      logic bod_on;
      logic bod_duty;
      logic wdt_run;
      logic wdt_on;
      logic io_latch;
   } pmc_gate_t;

   typedef struct packed {
      logic       fast_xtal;
      logic [1:0] slow_src;
      logic       slow_out;
      logic       radio_ok;
   } pmc_clk_t;
endpackage

/* File: rtl/pmc_sync.sv */
`timescale 1ns/1ns
// A bit changes only once the second and third stages agree.
module pmc_sync #(
   parameter int             W    = 1,
   parameter logic [W-1:0]   INIT = '0
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= INIT;
         s2_r <= INIT;
         s3_r <= INIT;
         q    <= INIT;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q    <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q);
      end
   end
endmodule // pmc_sync

/* File: verification/testbench.sv */
`timescale 1ns/1ns
module testbench;
   localparam logic [7:0] CT = pmc_pkg::CTRL_OFS;
   localparam logic [7:0] ST = pmc_pkg::STAT_OFS;
   localparam logic [7:0] WK = pmc_pkg::WAKE_OFS;
   localparam logic [1:0] OK = pmc_pkg::RESP_OKAY;
   localparam logic [1:0] ER = pmc_pkg::RESP_SLVERR;
   logic               aclk, aresetn, awvalid, wvalid, bvalid, bready;
   logic               awready, wready, arvalid, arready, rvalid, rready;
   logic               irq_any, rtc_evt, sensor_evt, reset_pin_n;
   logic               lf_resync, sys_reset, fx;
   logic [1:0]         bresp, rresp, src;
   logic [3:0]         wstrb;
   logic [7:0]         awaddr, araddr, wake_pins, gpio_drive, gpio_pad;
   logic [31:0]        wdata, rdata;
   pmc_pkg::pmc_gate_t gates;
   pmc_pkg::pmc_clk_t  clk_cfg;
   int                 fail_count, samples_checked, i;
   int                 lf_cnt = 0;
   int                 rst_cnt = 0;

   pmc_ctrl pmc_ctrl_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq_any,
      .wake_pins, .rtc_evt, .sensor_evt, .reset_pin_n, .gpio_drive,
      .gpio_pad, .gates, .clk_cfg, .lf_resync, .sys_reset);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Pulses last one cycle, so they are counted rather than sampled.
   always @(posedge aclk) begin
      if (lf_resync === 1'b1) lf_cnt <= lf_cnt + 1;
      if (sys_reset === 1'b1) rst_cnt <= rst_cnt + 1;
   end

   function automatic logic [31:0] gv();
      return {23'h0, gates.cpu_clk, gates.fast_clk, gates.medium_clk,
              gates.slow_clk, gates.periph_clk, gates.aon_pwr,
              gates.bod_on, gates.bod_duty, gates.io_latch};
   endfunction

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Handshakes are judged at the falling edge, where comb readies settle.
   task automatic wait_for(input int which);
      int   n;
      logic hit;
      n = 0;
      hit = 1'b0;
      while (hit !== 1'b1) begin
         @(negedge aclk);
         case (which)
            0: hit = awready & wready;
            1: hit = bvalid;
            2: hit = arready;
            3: hit = rvalid;
            default: hit = gates.cpu_clk;
         endcase
         n++;
         if (n > 40) begin
            chk("wait", 32'h1, 32'h0);
            close_out();
         end
      end
   endtask

   task automatic settle();
      repeat (3) @(negedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] resp);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      wait_for(0);
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      wait_for(1);
      chk("bresp", 32'(resp), 32'(bresp));
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] resp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      wait_for(2);
      @(posedge aclk);
      arvalid <= 1'b0;
      wait_for(3);
      chk("rdata", d, rdata);
      chk("rresp", 32'(resp), 32'(rresp));
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {irq_any, rtc_evt, sensor_evt} = '0;
      {awaddr, araddr, wdata, wake_pins, gpio_drive} = '0;
      {fail_count, samples_checked} = '0;
      reset_pin_n = 1'b1;
      wstrb = 4'hF;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      chk("gates", 32'h1FC, gv());
      chk("clk_cfg", 32'h0, 32'(clk_cfg));
      wr(ST, 32'h7F, OK);
      rd(ST, 32'h0, OK);
      rd(WK, 32'h0, OK);
      rd(8'h0C, 32'h0, ER);
      wr(8'h0C, 32'hFFFF_FFFF, ER);
      // Byte 0 unstrobed: neither the mode request nor the low bits land.
      wstrb <= 4'hE;
      wr(CT, 32'h0000_0049, OK);
      rd(CT, 32'h0, OK);
      wr(WK, 32'h0000_00FF, OK);
      rd(WK, 32'h0, OK);
      wstrb <= 4'hF;
      for (i = 0; i < 4; i++) begin
         fx = (i < 3);
         src = (i < 3) ? i[1:0] : 2'h0;
         wr(CT, {25'h0, 1'b1, src, fx, 3'h0}, OK);
         settle();
         chk("clk_cfg", {27'h0, fx, src, src != 2'h2, fx}, 32'(clk_cfg));
         rd(ST, {26'h0, fx, 5'h0}, OK);
      end
      wr(CT, 32'h1, OK);
      settle();
      chk("gates", 32'h0FC, gv());
      rd(ST, 32'h1, OK);
      @(posedge aclk);
      irq_any <= 1'b1;
      wait_for(4);
      @(posedge aclk);
      irq_any <= 1'b0;
      wr(WK, 32'h1, OK);
      for (i = 0; i < 3; i++) begin
         @(posedge aclk);
         gpio_drive <= 8'hA5 ^ i[7:0];
         wr(CT, 32'h3, OK);
         settle();
         chk("gates", 32'h06B, gv());
         chk("lf_resync", 32'(2 * i + 1), 32'(lf_cnt));
         @(posedge aclk);
         gpio_drive <= 8'h00;
         settle();
         chk("pad", 32'(8'hA5 ^ i[7:0]), 32'(gpio_pad));
         @(posedge aclk);
         rtc_evt <= (i == 0);
         sensor_evt <= (i == 1);
         wake_pins[0] <= (i == 2);
         wait_for(4);
         settle();
         chk("lf_resync", 32'(2 * i + 2), 32'(lf_cnt));
         chk("pad", 32'h0, 32'(gpio_pad));
         @(posedge aclk);
         rtc_evt <= 1'b0;
         sensor_evt <= 1'b0;
      end
      gpio_drive <= 8'h5A;
      wr(WK, 32'h2, OK);
      wr(CT, 32'h4A, OK);
      settle();
      chk("gates", 32'h001, gv());
      @(posedge aclk);
      gpio_drive <= 8'hFF;
      wake_pins[1] <= 1'b1;
      wait_for(4);
      settle();
      chk("sys_reset", 32'h1, 32'(rst_cnt));
      chk("pad", 32'h5A, 32'(gpio_pad));
      rd(ST, 32'h50, OK);
      rd(CT, 32'h0, OK);
      rd(WK, 32'h0, OK);
      wr(CT, 32'h80, OK);
      settle();
      chk("pad", 32'hFF, 32'(gpio_pad));
      wr(CT, 32'h6, OK);
      settle();
      chk("gates", 32'h0, gv() & 32'h1FE);
      @(posedge aclk);
      rtc_evt <= 1'b1;
      repeat (8) @(negedge aclk);
      chk("cpu_clk", 32'h0, 32'(gates.cpu_clk));
      @(posedge aclk);
      rtc_evt <= 1'b0;
      reset_pin_n <= 1'b0;
      wait_for(4);
      @(posedge aclk);
      reset_pin_n <= 1'b1;
      settle();
      chk("sys_reset", 32'h2, 32'(rst_cnt));
      rd(ST, 32'h08, OK);
      close_out();
   end
endmodule // testbench
